// File: rtl/uiec_pkg.sv
// Constants and types for the USB interrupt, error and endpoint control block.
// Assumes a 32-bit AXI4-Lite master and a 50 MHz system clock.
// Operation
// - One enable bit per interrupt status source
// - Attach enable exists only in host mode
// - Bit zero: reset enable device, detach host
// - Error flags hardware set, write one clears
// - Bit stuff violation sets its error flag
// - Overrun sets engine error, truncates stored data
// - Turnaround time-out sets its error flag
// - Non-integral byte data field sets flag
// - Data CRC failure sets its flag
// - Bit one: token CRC device, frame-end host
// - Packet identifier check failure sets flag
// - Error enables mirror flags, bit six zero
// - Sixteen independent endpoint control registers
// - Low-speed and retry bits: endpoint zero host
// - Low-speed bit enables direct low-speed link
// - Retry-off bit stops automatic NAK retries
// - Setup block applies only with both directions
// - Receive and transmit enables gate endpoint data
// - Stall status bit shows endpoint was stalled
// - Handshake enable controls handshake packets
// - Generator disabled holds output at idle level
// - Polarity bit selects active level
// - Counter advances only while counter enabled
// - Error summary set by enabled flags only
package uiec_pkg;

  localparam int ADDR_W = 8;
  localparam int NUM_EP = 16;
  localparam int BD_W = 10;
  localparam int PWM_W = 8;

  // Register byte addresses.
  localparam logic [7:0] OFF_IRQ_EN = 8'h00;
  localparam logic [7:0] OFF_ERR_FLAGS = 8'h04;
  localparam logic [7:0] OFF_ERR_EN = 8'h08;
  localparam logic [7:0] OFF_PWM_CTRL = 8'h0C;
  localparam logic [7:0] OFF_MODE = 8'h10;
  localparam logic [7:0] OFF_EP_BASE = 8'h40;
  localparam logic [7:0] OFF_EP_LAST = 8'h7C;

  // Implemented-bit masks and field positions.
  localparam logic [7:0] IE_MASK_DEV = 8'hBF;
  localparam logic [7:0] IE_MASK_HOST = 8'hFF;
  localparam logic [7:0] ERR_MASK = 8'hBF;
  localparam logic [7:0] EP_MASK = 8'h1F;
  localparam logic [7:0] EP0_MASK_HOST = 8'hDF;
  localparam logic [15:0] PWM_MASK = 16'h8300;
  localparam int IE_ERR_SUM = 1;
  localparam int ERR_STUFF = 7;
  localparam int ERR_XFER = 5;
  localparam int ERR_TURN = 4;
  localparam int ERR_FIELD = 3;
  localparam int ERR_DCRC = 2;
  localparam int ERR_TOKFRM = 1;
  localparam int ERR_PID = 0;
  localparam int EP_HSHK = 0;
  localparam int EP_STALL = 1;
  localparam int EP_TX = 2;
  localparam int EP_RX = 3;
  localparam int EP_SETUP_BLK = 4;
  localparam int EP_RETRY_OFF = 6;
  localparam int EP_LOWSPEED_DIRECT_EN = 7;
  localparam int PWM_EN = 15;
  localparam int PWM_POL = 9;
  localparam int PWM_CNT = 8;
  localparam int MODE_HOST = 0;
  localparam int MODE_SUM = 1;
  localparam int MODE_IRQ = 2;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic {BUS_IDLE = 1'b0, BUS_RESP = 1'b1} uiec_bus_e;

  // Link-side error events, one-cycle pulses.
  typedef struct packed {
    logic bitstuff;
    logic turnaround;
    logic fieldSize;
    logic dataCrc;
    logic tokenCrc;
    logic frameEnd;
    logic pidCheck;
  } uiec_errev_s;

  // Policy of the endpoint named by the current token.
  typedef struct packed {
    logic rxAllow;
    logic txAllow;
    logic setupAllow;
    logic handshake;
    logic stalled;
  } uiec_epgate_s;

endpackage

// File: rtl/uiec_top.sv
// USB interrupt enable, error flag, endpoint control and VBUS PWM control.
// Assumes an AXI4-Lite master, pulses from the link engine and levels
// from the interrupt status register kept elsewhere.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module uiec_top (
  // Clock, reset and freeze
  input wire logic clock,
  input wire logic reset,
  input wire logic clockEnable,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Link engine events, interrupt status levels and PWM period and duty
  input wire logic [7:0] irqSources,
  input wire uiec_pkg::uiec_errev_s errEvent,
  input wire logic [3:0] tokenEp,
  input wire logic stallEvent,
  input wire logic rxPktStart,
  input wire logic rxByteValid,
  input wire logic [9:0] bdByteCount,
  input wire logic [7:0] pwmPeriod,
  input wire logic [7:0] pwmDuty,
  // Results
  output logic irqRequest,
  output uiec_pkg::uiec_epgate_s epGate,
  output logic lowspeedDirect,
  output logic nakRetry,
  output logic rxStoreEn,
  output logic vbusPwm
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic isEp(input logic [7:0] a);
    isEp = (a >= uiec_pkg::OFF_EP_BASE) && (a <= uiec_pkg::OFF_EP_LAST);
  endfunction

  function automatic logic [3:0] epIdx(input logic [7:0] a);
    logic [7:0] d;
    d = a - uiec_pkg::OFF_EP_BASE;
    epIdx = d[5:2];
  endfunction

  function automatic logic [7:0] epMask(input logic [3:0] i, input logic h);
    epMask = (i == 4'h0 && h) ? uiec_pkg::EP0_MASK_HOST : uiec_pkg::EP_MASK;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] usbIrqEnable;
  logic [7:0] usbErrorFlags;
  logic [7:0] usbErrorIrqEnable;
  logic [15:0] vbusPwmControl;
  logic [7:0] endpointControl [uiec_pkg::NUM_EP];
  logic hostMode;
  logic errorSummaryFlag;
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  uiec_pkg::uiec_bus_e wrState;
  localparam int BD_W_L = uiec_pkg::BD_W;
  logic [BD_W_L-1:0] rxCount;
  logic [7:0] pwmCount;

  logic wrFire;
  logic next_awHeld;
  logic next_wHeld;
  logic lane0;
  logic [7:0] ieMask;
  logic [7:0] ieRead;
  logic [7:0] errSet;
  logic [7:0] errClr;
  logic [7:0] statusVec;
  logic [7:0] tokEp;
  logic overrun;

  assign lane0 = wStrbQ[0];
  assign ieMask = hostMode ? uiec_pkg::IE_MASK_HOST : uiec_pkg::IE_MASK_DEV;
  assign ieRead = usbIrqEnable & ieMask;
  assign tokEp = endpointControl[tokenEp] & epMask(tokenEp, hostMode);

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  assign wrFire = awHeld && wHeld && (wrState == uiec_pkg::BUS_IDLE);
  assign next_awHeld = (awvalid && awready) || (awHeld && !wrFire);
  assign next_wHeld = (wvalid && wready) || (wHeld && !wrFire);

  always_ff @(posedge clock) begin
    if (reset) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      awAddrQ <= uiec_pkg::RST_BYTE;
      wDataQ <= '0;
      wStrbQ <= '0;
    end else if (clockEnable) begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awready <= !next_awHeld && !(wrFire || wrState == uiec_pkg::BUS_RESP);
      wready <= !next_wHeld && !(wrFire || wrState == uiec_pkg::BUS_RESP);
      if (awvalid && awready) begin
        awAddrQ <= awaddr;
      end
      if (wvalid && wready) begin
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wrState <= uiec_pkg::BUS_IDLE;
      bvalid <= 1'b0;
      bresp <= uiec_pkg::RESP_OKAY;
    end else if (clockEnable) begin
      unique case (wrState)
        uiec_pkg::BUS_IDLE: begin
          if (wrFire) begin
            wrState <= uiec_pkg::BUS_RESP;
            bvalid <= 1'b1;
            bresp <= (isEp(awAddrQ) || awAddrQ == uiec_pkg::OFF_IRQ_EN
              || awAddrQ == uiec_pkg::OFF_ERR_FLAGS || awAddrQ == uiec_pkg::OFF_ERR_EN
              || awAddrQ == uiec_pkg::OFF_PWM_CTRL || awAddrQ == uiec_pkg::OFF_MODE)
              ? uiec_pkg::RESP_OKAY : uiec_pkg::RESP_DECERR;
          end
        end
        uiec_pkg::BUS_RESP: begin
          if (bready) begin
            wrState <= uiec_pkg::BUS_IDLE;
            bvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      usbIrqEnable <= uiec_pkg::RST_BYTE;
      usbErrorIrqEnable <= uiec_pkg::RST_BYTE;
      vbusPwmControl <= uiec_pkg::RST_WORD;
      hostMode <= 1'b0;
    end else if (clockEnable && wrFire) begin
      if (awAddrQ == uiec_pkg::OFF_IRQ_EN && lane0) begin
        usbIrqEnable <= wDataQ[7:0];
      end
      if (awAddrQ == uiec_pkg::OFF_ERR_EN && lane0) begin
        usbErrorIrqEnable <= wDataQ[7:0] & uiec_pkg::ERR_MASK;
      end
      if (awAddrQ == uiec_pkg::OFF_PWM_CTRL && wStrbQ[1]) begin
        vbusPwmControl[15:8] <= wDataQ[15:8] & uiec_pkg::PWM_MASK[15:8];
      end
      if (awAddrQ == uiec_pkg::OFF_MODE && lane0) begin
        hostMode <= wDataQ[uiec_pkg::MODE_HOST];
      end
    end
  end

  // ----------------------------------------
  // Error flags
  // ----------------------------------------
  // overrun beyond count
  assign overrun = rxByteValid && (rxCount >= bdByteCount);

  always_comb begin
    errSet = '0;
    errSet[uiec_pkg::ERR_STUFF] = errEvent.bitstuff;
    errSet[uiec_pkg::ERR_XFER] = overrun;
    errSet[uiec_pkg::ERR_TURN] = errEvent.turnaround;
    errSet[uiec_pkg::ERR_FIELD] = errEvent.fieldSize;
    errSet[uiec_pkg::ERR_DCRC] = errEvent.dataCrc;
    errSet[uiec_pkg::ERR_TOKFRM] = hostMode ? errEvent.frameEnd : errEvent.tokenCrc;
    errSet[uiec_pkg::ERR_PID] = errEvent.pidCheck;
  end

  assign errClr = (wrFire && awAddrQ == uiec_pkg::OFF_ERR_FLAGS && lane0)
    ? wDataQ[7:0] : uiec_pkg::RST_BYTE;

  always_ff @(posedge clock) begin
    if (reset) begin
      usbErrorFlags <= uiec_pkg::RST_BYTE;
    end else if (clockEnable) begin
      usbErrorFlags <= ((usbErrorFlags & ~errClr) | errSet) & uiec_pkg::ERR_MASK;
    end
  end

  // ----------------------------------------
  // Receive truncation
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      rxCount <= '0;
      rxStoreEn <= 1'b0;
    end else if (clockEnable) begin
      rxStoreEn <= rxByteValid && !overrun && tokEp[uiec_pkg::EP_RX];
      if (rxPktStart) begin
        rxCount <= '0;
      end else if (rxByteValid && !overrun) begin
        rxCount <= rxCount + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Endpoint control
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < uiec_pkg::NUM_EP; i++) begin
        endpointControl[i] <= uiec_pkg::RST_BYTE;
      end
    end else if (clockEnable) begin
      for (int i = 0; i < uiec_pkg::NUM_EP; i++) begin
        if (wrFire && isEp(awAddrQ) && lane0 && epIdx(awAddrQ) == 4'(i)) begin
          endpointControl[i] <= wDataQ[7:0] & epMask(4'(i), hostMode);
        end
        if (stallEvent && tokenEp == 4'(i)) begin
          endpointControl[i][uiec_pkg::EP_STALL] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      epGate <= '0;
      lowspeedDirect <= 1'b0;
      nakRetry <= 1'b0;
    end else if (clockEnable) begin
      epGate.rxAllow <= tokEp[uiec_pkg::EP_RX];
      epGate.txAllow <= tokEp[uiec_pkg::EP_TX];
      epGate.setupAllow <= tokEp[uiec_pkg::EP_RX] && tokEp[uiec_pkg::EP_TX]
        && !tokEp[uiec_pkg::EP_SETUP_BLK];
      epGate.handshake <= tokEp[uiec_pkg::EP_HSHK];
      epGate.stalled <= tokEp[uiec_pkg::EP_STALL];
      lowspeedDirect <= hostMode && endpointControl[0][uiec_pkg::EP_LOWSPEED_DIRECT_EN];
      nakRetry <= hostMode && !endpointControl[0][uiec_pkg::EP_RETRY_OFF];
    end
  end

  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  always_comb begin
    statusVec = irqSources;
    statusVec[uiec_pkg::IE_ERR_SUM] = errorSummaryFlag;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      errorSummaryFlag <= 1'b0;
      irqRequest <= 1'b0;
    end else if (clockEnable) begin
      errorSummaryFlag <= |(usbErrorFlags & usbErrorIrqEnable);
      // bit six by mode, single request
      irqRequest <= |(statusVec & ieRead);
    end
  end

  // ----------------------------------------
  // VBUS PWM
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      pwmCount <= '0;
      vbusPwm <= 1'b0;
    end else if (clockEnable) begin
      if (!vbusPwmControl[uiec_pkg::PWM_EN]) begin
        pwmCount <= '0;
        vbusPwm <= vbusPwmControl[uiec_pkg::PWM_POL];
      end else begin
        if (vbusPwmControl[uiec_pkg::PWM_CNT]) begin
          pwmCount <= (pwmCount >= pwmPeriod) ? '0 : pwmCount + 1'b1;
        end
        vbusPwm <= (pwmCount < pwmDuty) ^ vbusPwmControl[uiec_pkg::PWM_POL];
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= uiec_pkg::RESP_OKAY;
    end else if (clockEnable) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        arready <= 1'b0;
        rresp <= uiec_pkg::RESP_OKAY;
        rdata <= '0;
        if (isEp(araddr)) begin
          rdata[7:0] <= endpointControl[epIdx(araddr)] & epMask(epIdx(araddr), hostMode);
        end else if (araddr == uiec_pkg::OFF_IRQ_EN) begin
          rdata[7:0] <= ieRead;
        end else if (araddr == uiec_pkg::OFF_ERR_FLAGS) begin
          rdata[7:0] <= usbErrorFlags;
        end else if (araddr == uiec_pkg::OFF_ERR_EN) begin
          rdata[7:0] <= usbErrorIrqEnable;
        end else if (araddr == uiec_pkg::OFF_PWM_CTRL) begin
          rdata[15:0] <= vbusPwmControl;
        end else if (araddr == uiec_pkg::OFF_MODE) begin
          rdata[uiec_pkg::MODE_HOST] <= hostMode;
          rdata[uiec_pkg::MODE_SUM] <= errorSummaryFlag;
          rdata[uiec_pkg::MODE_IRQ] <= irqRequest;
        end else begin
          rresp <= uiec_pkg::RESP_DECERR;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end else if (!rvalid) begin
        arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  dev_attach_a: assert property (
    clockEnable && arvalid && arready && araddr == uiec_pkg::OFF_IRQ_EN && !hostMode
    |=> !rdata[6]) else $error("attach enable visible in device mode");

  err_clear_a: assert property (
    clockEnable |=> (usbErrorFlags & $past(errClr) & ~$past(errSet)) == 8'h00)
    else $error("written-one error flag not cleared");

  err_set_a: assert property (
    clockEnable && |(errSet & uiec_pkg::ERR_MASK)
    |=> (usbErrorFlags & $past(errSet) & uiec_pkg::ERR_MASK)
      == ($past(errSet) & uiec_pkg::ERR_MASK)) else $error("error event lost");

  trunc_store_a: assert property (
    clockEnable && overrun |=> !rxStoreEn && usbErrorFlags[uiec_pkg::ERR_XFER])
    else $error("overrun byte stored or not flagged");

  tok_crc_a: assert property (
    clockEnable && !hostMode && errEvent.tokenCrc |=> usbErrorFlags[uiec_pkg::ERR_TOKFRM])
    else $error("token CRC error not flagged");

  ep_upper_a: assert property (
    clockEnable && arvalid && arready && isEp(araddr) && araddr != uiec_pkg::OFF_EP_BASE
    |=> rdata[7:6] == 2'h0) else $error("endpoint upper bits not zero");

  setup_gate_a: assert property (
    clockEnable && tokEp[uiec_pkg::EP_RX] && tokEp[uiec_pkg::EP_TX]
    && tokEp[uiec_pkg::EP_SETUP_BLK] |=> !epGate.setupAllow)
    else $error("setup allowed while blocked");

  irq_path_a: assert property (
    clockEnable && |(usbErrorFlags & usbErrorIrqEnable) && usbIrqEnable[1]
    ##1 clockEnable && usbIrqEnable[1] |=> irqRequest)
    else $error("enabled error gives no request");

  pwm_idle_a: assert property (
    clockEnable && !vbusPwmControl[uiec_pkg::PWM_EN]
    |=> vbusPwm == $past(vbusPwmControl[uiec_pkg::PWM_POL]))
    else $error("pwm output not idle");

  pwm_hold_a: assert property (
    clockEnable && vbusPwmControl[uiec_pkg::PWM_EN] && !vbusPwmControl[uiec_pkg::PWM_CNT]
    |=> $stable(pwmCount)) else $error("pwm counter moved while stopped");

  write_cov: cover property (wrFire ##1 bvalid && bready);
  clear_cov: cover property (|(errClr & errSet));
  pwm_cov: cover property (vbusPwmControl[uiec_pkg::PWM_EN] && $rose(vbusPwm));

endmodule // uiec_top

// File: testbench/uiec_link_model.sv
// Stand-in for the link engine: error pulses, stall events, token endpoint and packets.
// Assumes the bench calls its tasks from one process; all changes follow a rising edge.
`timescale 1ns/1ps
module uiec_link_model (
  // Clock
  input wire logic clock,
  // Link events
  output uiec_pkg::uiec_errev_s errEvent,
  output logic [3:0] tokenEp,
  output logic stallEvent,
  output logic rxPktStart,
  output logic rxByteValid,
  output logic [9:0] bdByteCount
);
  initial begin
    errEvent = '0;
    tokenEp = 4'h0;
    stallEvent = 1'b0;
    rxPktStart = 1'b0;
    rxByteValid = 1'b0;
    bdByteCount = 10'h000;
  end

  // Each event is a pulse of exactly one cycle, as the real engine makes it.
  task automatic pulse_error(input logic [6:0] ev);
    @(posedge clock);
    errEvent <= uiec_pkg::uiec_errev_s'(ev);
    @(posedge clock);
    errEvent <= '0;
  endtask

  task automatic point_ep(input logic [3:0] ep);
    @(posedge clock);
    tokenEp <= ep;
  endtask

  task automatic stall_ep(input logic [3:0] ep);
    @(posedge clock);
    tokenEp <= ep;
    stallEvent <= 1'b1;
    @(posedge clock);
    stallEvent <= 1'b0;
  endtask

  // Bytes come one every other cycle; the limit is given with the packet start.
  task automatic send_packet(input logic [9:0] limit, input int nBytes);
    @(posedge clock);
    bdByteCount <= limit;
    rxPktStart <= 1'b1;
    @(posedge clock);
    rxPktStart <= 1'b0;
    repeat (nBytes) begin
      @(posedge clock);
      rxByteValid <= 1'b1;
      @(posedge clock);
      rxByteValid <= 1'b0;
    end
  endtask
endmodule // uiec_link_model

// File: testbench/uiec_top_test.sv
// Self-checking bench for the interrupt, error, endpoint and VBUS control block.
// Assumes the link model drives the event inputs; the bench is the AXI4-Lite master.
`timescale 1ns/1ps
module uiec_top_test;
  typedef struct packed {logic [31:0] data; logic [1:0] resp;} uiec_rexp_s;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, irqSources = 8'h00;
  logic [7:0] pwmPeriod = 8'h04, pwmDuty = 8'h02;
  logic [31:0] wdata = 32'h00000000, rnd = 32'h1E86570B;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irqRequest, lowspeedDirect, nakRetry;
  logic rxStoreEn, vbusPwm, stallEvent, rxPktStart, rxByteValid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] tokenEp;
  logic [9:0] bdByteCount;
  logic [7:0] epVal [16];
  uiec_pkg::uiec_errev_s errEvent;
  uiec_pkg::uiec_epgate_s epGate;
  uiec_rexp_s expQ[$];
  uiec_rexp_s got;
  int failCount = 0, nTests = 0, storeCount = 0, n, m, h, s0;

  always #10 clock = ~clock;

  uiec_link_model u_link (.clock(clock), .errEvent(errEvent), .tokenEp(tokenEp),
    .stallEvent(stallEvent), .rxPktStart(rxPktStart), .rxByteValid(rxByteValid),
    .bdByteCount(bdByteCount));

  uiec_top u_dut (.clock(clock), .reset(reset), .clockEnable(1'b1), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irqSources(irqSources), .errEvent(errEvent), .tokenEp(tokenEp),
    .stallEvent(stallEvent), .rxPktStart(rxPktStart), .rxByteValid(rxByteValid),
    .bdByteCount(bdByteCount), .pwmPeriod(pwmPeriod), .pwmDuty(pwmDuty),
    .irqRequest(irqRequest), .epGate(epGate), .lowspeedDirect(lowspeedDirect),
    .nakRetry(nakRetry), .rxStoreEn(rxStoreEn), .vbusPwm(vbusPwm));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic give_up();
    failCount++;
    $display("BAD bus answer expected within 50 cycles seen none");
    report_and_stop();
  endtask

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [7:0] ep_addr(input int i);
    return uiec_pkg::OFF_EP_BASE + 8'(i * 4);
  endfunction

  // Bit 1 takes the token CRC event in device mode and the frame-end event in host mode.
  function automatic logic [31:0] flag_of(input int i, input logic host);
    case (i)
      0: return 32'h00000001;
      1: return host ? 32'h00000002 : 32'h00000000;
      2: return host ? 32'h00000000 : 32'h00000002;
      6: return 32'h00000080;
      default: return 32'h00000001 << (i - 1);
    endcase
  endfunction

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hF, input logic [1:0] r = uiec_pkg::RESP_OKAY);
    int i;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (i == 50) give_up();
    check("bresp", {30'h0, bresp}, {30'h0, r});
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r = uiec_pkg::RESP_OKAY);
    int i;
    @(posedge clock);
    expQ.push_back('{d, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (i == 50) give_up();
    rready <= 1'b0;
  endtask

  task automatic irq_is(input logic e);
    repeat (4) @(posedge clock);
    check("irqRequest", {31'h0, irqRequest}, {31'h0, e});
  endtask

  task automatic count_high();
    h = 0;
    repeat (16) begin
      @(posedge clock);
      if (vbusPwm === 1'b1) h++;
    end
  endtask

  // Read results are compared in the handshake cycle, oldest note first.
  always @(posedge clock) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      got = expQ.pop_front();
      check("rdata", rdata, got.data);
      check("rresp", {30'h0, rresp}, {30'h0, got.resp});
    end
    if (rxStoreEn === 1'b1) storeCount++;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    for (n = 0; n < 5; n++) axi_read(8'(n * 4), 32'h00000000);
    for (n = 0; n < 16; n++) axi_read(ep_addr(n), 32'h00000000);
    axi_read(8'h20, 32'h00000000, uiec_pkg::RESP_DECERR);
    axi_write(8'h84, 32'hFFFFFFFF, 4'hF, uiec_pkg::RESP_DECERR);
    axi_write(uiec_pkg::OFF_IRQ_EN, 32'hFFFFFFFF);
    axi_read(uiec_pkg::OFF_IRQ_EN, 32'h000000BF);
    axi_write(uiec_pkg::OFF_ERR_EN, 32'hFFFFFFFF);
    axi_read(uiec_pkg::OFF_ERR_EN, 32'h000000BF);
    for (m = 0; m < 2; m++) begin
      axi_write(uiec_pkg::OFF_MODE, 32'(m));
      if (m == 1) axi_read(uiec_pkg::OFF_IRQ_EN, 32'h000000FF);
      for (n = 0; n < 7; n++) begin
        u_link.pulse_error(7'h01 << n);
        axi_read(uiec_pkg::OFF_ERR_FLAGS, flag_of(n, m[0]));
        axi_write(uiec_pkg::OFF_ERR_FLAGS, 32'h000000FF);
      end
    end
    axi_write(uiec_pkg::OFF_MODE, 32'h00000000);
    axi_write(uiec_pkg::OFF_IRQ_EN, 32'h00000002);
    rnd = xorshift(rnd);
    irqSources <= rnd[7:0] | 8'h02;
    u_link.pulse_error(7'h49);
    axi_read(uiec_pkg::OFF_ERR_FLAGS, 32'h00000085);
    axi_write(uiec_pkg::OFF_ERR_FLAGS, 32'h00000004);
    axi_read(uiec_pkg::OFF_ERR_FLAGS, 32'h00000081);
    irq_is(1'b1);
    axi_read(uiec_pkg::OFF_MODE, 32'h00000006);
    axi_write(uiec_pkg::OFF_ERR_EN, 32'h00000000);
    irq_is(1'b0);
    axi_read(uiec_pkg::OFF_MODE, 32'h00000000);
    axi_write(uiec_pkg::OFF_ERR_FLAGS, 32'h000000FF);
    axi_write(uiec_pkg::OFF_MODE, 32'h00000001);
    for (n = 0; n < 8; n++) begin
      if (n != 1) begin
        axi_write(uiec_pkg::OFF_IRQ_EN, 32'h00000001 << n);
        irqSources <= 8'h01 << n;
        irq_is(1'b1);
        irqSources <= ~(8'h01 << n);
        irq_is(1'b0);
      end
    end
    axi_write(ep_addr(0), 32'hFFFFFFFF);
    axi_read(ep_addr(0), 32'h000000DF);
    check("lowspeedDirect", {31'h0, lowspeedDirect}, 32'h00000001);
    check("nakRetry", {31'h0, nakRetry}, 32'h00000000);
    axi_write(ep_addr(0), 32'h00000000);
    repeat (2) @(posedge clock);
    check("lowspeedDirect", {31'h0, lowspeedDirect}, 32'h00000000);
    check("nakRetry", {31'h0, nakRetry}, 32'h00000001);
    axi_write(ep_addr(1), 32'h000000FF);
    axi_read(ep_addr(1), 32'h0000001F);
    axi_write(uiec_pkg::OFF_MODE, 32'h00000000);
    for (n = 0; n < 16; n++) begin
      rnd = xorshift(rnd);
      epVal[n] = rnd[7:0] & uiec_pkg::EP_MASK;
      axi_write(ep_addr(n), rnd);
    end
    for (n = 0; n < 16; n++) begin
      axi_read(ep_addr(n), {24'h0, epVal[n]});
      u_link.point_ep(4'(n));
      repeat (3) @(posedge clock);
      check("epGate", {27'h0, epGate}, {27'h0, epVal[n][3], epVal[n][2],
        epVal[n][3] & epVal[n][2] & ~epVal[n][4], epVal[n][0], epVal[n][1]});
    end
    u_link.stall_ep(4'h9);
    axi_read(ep_addr(9), {24'h0, epVal[9] | 8'h02});
    axi_write(ep_addr(3), 32'h00000009);
    u_link.point_ep(4'h3);
    s0 = storeCount;
    u_link.send_packet(10'h003, 5);
    repeat (3) @(posedge clock);
    check("stored bytes", 32'(storeCount - s0), 32'h00000003);
    axi_read(uiec_pkg::OFF_ERR_FLAGS, 32'h00000020);
    axi_write(ep_addr(3), 32'h00000004);
    s0 = storeCount;
    u_link.send_packet(10'h008, 2);
    repeat (3) @(posedge clock);
    check("stored bytes", 32'(storeCount - s0), 32'h00000000);
    axi_write(uiec_pkg::OFF_PWM_CTRL, 32'h00008300, 4'h1);
    axi_read(uiec_pkg::OFF_PWM_CTRL, 32'h00000000);
    axi_write(uiec_pkg::OFF_PWM_CTRL, 32'h00000200, 4'h2);
    axi_read(uiec_pkg::OFF_PWM_CTRL, 32'h00000200);
    count_high();
    check("idle high", 32'(h), 32'd16);
    axi_write(uiec_pkg::OFF_PWM_CTRL, 32'h00000000, 4'h2);
    count_high();
    check("idle low", 32'(h), 32'd0);
    axi_write(uiec_pkg::OFF_PWM_CTRL, 32'h00008100, 4'h2);
    count_high();
    check("running", {31'h0, h > 0 && h < 16}, 32'h00000001);
    axi_write(uiec_pkg::OFF_PWM_CTRL, 32'h00008000, 4'h2);
    repeat (2) @(posedge clock);
    count_high();
    check("frozen", {31'h0, h == 0 || h == 16}, 32'h00000001);
    report_and_stop();
  end
endmodule // uiec_top_test
